/* File: shared/uwr_defines.vh */
// Constants for the wake, reset and attach controller: register offsets,
// bit positions, reset values and timing figures.
// Assumes an 8-bit register port and a 50 ns system clock.
`ifndef UWR_DEFINES_VH
`define UWR_DEFINES_VH

// Register offsets
`define UWR_ADDR_CTL 4'h0
`define UWR_ADDR_PIN 4'h1
`define UWR_ADDR_GPO 4'h2
`define UWR_ADDR_EVT 4'h3
`define UWR_ADDR_ENA 4'h4
`define UWR_ADDR_GIE 4'h5
`define UWR_ADDR_INBUF 4'h6
`define UWR_ADDR_STAT 4'h7

// Control register fields
`define UWR_CTL_PDREQ 0
`define UWR_CTL_RWREQ 1
`define UWR_CTL_HWOSC 2
`define UWR_CTL_SOFTRST 3
`define UWR_CTL_ATTACH 4
`define UWR_CTL_PULLUP_GATE 5
`define UWR_CTL_MASK 8'h3F

// Pin control register fields
`define UWR_PIN_DUPLEX 0
`define UWR_PIN_IRQLVL 1
`define UWR_PIN_IRQPOL 2
`define UWR_PIN_MSEL_LO 4
`define UWR_PIN_MSEL_HI 5
`define UWR_PIN_MASK 8'h37
`define UWR_GPO_MASK 8'h0F

// Event flag and enable fields
`define UWR_EVT_OSCOK 0
`define UWR_EVT_RWDONE 1
`define UWR_EVT_SUSP 2
`define UWR_EVT_BUSRST 3
`define UWR_EVT_BUSRSTDN 4
`define UWR_EVT_VBON 5
`define UWR_EVT_VBOFF 6
`define UWR_EVT_MASK 8'h7F
`define UWR_EVT_BUSRST_KEEP 8'h18

// Buffer-free flags: endpoints 0, 2 and 3
`define UWR_INBUF_MASK 8'h0D
`define UWR_INBUF_RST 8'h0D

// Multi-function output selections
`define UWR_MSEL_VBUS 2'h0
`define UWR_MSEL_OSC 2'h1
`define UWR_MSEL_SUSP 2'h2
`define UWR_MSEL_BUSRST 2'h3

// Timing
`define UWR_CLK_PERIOD_NS 50
`define UWR_CLK_KHZ 20000
`define UWR_RESUME_MS 10
`define UWR_IDLE_MS 5
`define UWR_SUSPEND_MS 3
`define UWR_SE0_RESET_NS 21330
`define UWR_OSC_SETTLE_US 100

`endif

/* File: verilog/uwr_sync.v */
// Two-flop synchronisers for pins that arrive from outside the clock domain.
// Assumes the inputs are slow against clk; multi-bit values are not coherent.
`timescale 1ns/1ns
module uwr_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire srst,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      // First stage feeds only the second stage
      always @(posedge clk) begin
        if (srst) begin
          stage1[i] <= INIT[i];
          stage2[i] <= INIT[i];
        end else begin
          stage1[i] <= asyncIn[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign syncOut = stage2;
endmodule

/* File: verilog/uwr_wake_reset_ctrl.v */
// Power-down exit, reset scopes and bus attach control for a USB peripheral.
// Assumes srst is the power-on reset and all pins are asynchronous to clk.
//
// Summary of operation
// - Clearing power-down or chip reset ends power-down
// - Remote wake: restart oscillator, then 10 ms K
// - Resume K only after 5 ms idle bus
// - Set remote-wake-done flag when resume ends
// - Host-wake enabled: D+ falling edge restarts oscillator
// - Power-on sets all three buffer-free flags
// - Soft chip reset equals reset pin, self-holding
// - Chip reset keeps attach, outputs, output selector
// - Chip reset keeps serial and power-down controls
// - Chip reset clears pullup gate, event flags, enables
// - SE0 for 21.33 us flags and applies bus reset
// - Bus reset also keeps global enable, data registers
// - Bus reset keeps its own flags and enables
// - VBUS rise and fall each set a flag
// - Multi-function output can show VBUS, even powered down
// - Attach bit connects the D+ pullup
// - Pullup gate drops pullup while VBUS absent
// - Power-down stops oscillator, keeps interrupt, watches D+
// - Set oscillator-stable flag once clock has settled
// - 3 ms idle sets suspend flag, no auto power-down
`timescale 1ns/1ns
`include "uwr_defines.vh"
module uwr_wake_reset_ctrl #(
  parameter [17:0] RESUME_CYC = `UWR_RESUME_MS * `UWR_CLK_KHZ,
  parameter [17:0] IDLE_CYC = `UWR_IDLE_MS * `UWR_CLK_KHZ,
  parameter [17:0] SUSPEND_CYC = `UWR_SUSPEND_MS * `UWR_CLK_KHZ
) (
  input wire clk,
  input wire srst,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire resetPinN,
  input wire vbusSenseInput,
  input wire dpIn,
  output reg dpOut,
  output reg dpOe,
  input wire dmIn,
  output reg dmOut,
  output reg dmOe,
  output reg pullupOn,
  output reg oscEnable,
  output reg irqPin,
  output reg multiFunctionOutput,
  output reg [3:0] generalOutputs,
  output reg serialDuplexSelect
);
  localparam [31:0] SE0_FULL = (`UWR_SE0_RESET_NS + `UWR_CLK_PERIOD_NS - 1) / `UWR_CLK_PERIOD_NS;
  localparam [8:0] SE0_CYC = SE0_FULL[8:0];
  localparam [31:0] OSC_FULL = `UWR_OSC_SETTLE_US * 1000 / `UWR_CLK_PERIOD_NS;
  localparam [11:0] OSC_CYC = OSC_FULL[11:0];

  // Wake state machine
  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_PDOWN = 3'h1;
  localparam [2:0] ST_HOSTWAKE = 3'h2;
  localparam [2:0] ST_REMOTE = 3'h3;
  localparam [2:0] ST_RESUME = 3'h4;
  localparam [2:0] ST_AWAKE = 3'h5;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] ctl;
  reg [7:0] pinCtl;
  reg [7:0] evtFlags;
  reg [7:0] evtEnable;
  reg globalIrqEnable;
  reg [7:0] inBufFlags;
  reg pdPrev;
  reg dpPrev;
  reg vbusPrev;
  reg [17:0] idleCnt;
  reg [8:0] se0Cnt;
  reg [11:0] settleCnt;
  reg [17:0] resumeCnt;
  reg oscStable;
  reg busResetActive;
  reg irqPrev;

  wire [3:0] pinsSync;
  wire dpS;
  wire dmS;
  wire vbusS;
  wire resetPinSyncN;

  // Reset pin and D+ settle at idle, so power-on adds no chip reset or false D+ fall
  uwr_sync #(
    .WIDTH(4),
    .INIT(4'h9)
  ) uSync (
    .clk(clk),
    .srst(srst),
    .asyncIn({resetPinN, vbusSenseInput, dmIn, dpIn}),
    .syncOut(pinsSync)
  );
  assign dpS = pinsSync[0];
  assign dmS = pinsSync[1];
  assign vbusS = pinsSync[2];
  assign resetPinSyncN = pinsSync[3];

  wire pdReq = ctl[`UWR_CTL_PDREQ];
  wire rwReq = ctl[`UWR_CTL_RWREQ];
  wire hwOsc = ctl[`UWR_CTL_HWOSC];
  // Soft bit and pin are one reset; the bit is never cleared by it
  wire chipRst = !resetPinSyncN || ctl[`UWR_CTL_SOFTRST];
  wire wrCtl = wr && addr == `UWR_ADDR_CTL;
  wire wrEvt = wr && addr == `UWR_ADDR_EVT;
  wire wrInBuf = wr && addr == `UWR_ADDR_INBUF;

  // Bus line conditions, full speed: J is D+ high, D- low
  wire busIdle = dpS && !dmS;
  wire se0 = !dpS && !dmS;
  wire dpFall = dpPrev && !dpS;
  wire suspendHit = busIdle && idleCnt == SUSPEND_CYC - 18'h00001;
  wire idleLong = idleCnt >= IDLE_CYC;
  wire busRstHit = se0 && se0Cnt == SE0_CYC - 9'h001;
  wire busRstDone = busResetActive && !se0;
  wire oscHit = state != ST_PDOWN && !oscStable && settleCnt == OSC_CYC - 12'h001;
  wire resumeEnd = state == ST_RESUME && resumeCnt == RESUME_CYC - 18'h00001;
  // Power-down is entered on a fresh request, so a kept bit does not re-enter
  wire pdEnter = pdReq && !pdPrev;

  // Next wake state
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (rwReq) begin
          next_state = ST_REMOTE;
        end else if (pdEnter) begin
          next_state = ST_PDOWN;
        end
      end
      ST_PDOWN: begin
        if (!pdReq) begin
          next_state = ST_RUN;
        end else if (rwReq) begin
          next_state = ST_REMOTE;
        end else if (hwOsc && dpFall) begin
          next_state = ST_HOSTWAKE;
        end
      end
      ST_HOSTWAKE: begin
        if (!pdReq) begin
          next_state = ST_RUN;
        end
      end
      ST_REMOTE: begin
        // Oscillator must be settled and the bus quiet long enough
        if (oscStable && idleLong) begin
          next_state = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (resumeEnd) begin
          next_state = ST_AWAKE;
        end
      end
      ST_AWAKE: begin
        // Waits for the processor to drop both the wake request and the power-down request
        if (!rwReq && !pdReq) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // Wake state; chip reset pulls the device out of power-down
  always @(posedge clk) begin
    if (srst) begin
      state <= ST_RUN;
      pdPrev <= 1'b0;
    end else if (chipRst) begin
      state <= ST_RUN;
      pdPrev <= pdReq;
    end else begin
      state <= next_state;
      pdPrev <= pdReq;
    end
  end

  // Oscillator restart and settle timing
  always @(posedge clk) begin
    if (srst) begin
      settleCnt <= 12'h000;
      oscStable <= 1'b0;
      oscEnable <= 1'b0;
    end else begin
      oscEnable <= next_state != ST_PDOWN;
      if (state == ST_PDOWN) begin
        settleCnt <= 12'h000;
        oscStable <= 1'b0;
      end else if (!oscStable) begin
        settleCnt <= settleCnt + 12'h001;
        oscStable <= oscHit;
      end
    end
  end

  // Bus idle, SE0 and resume timers; idle and SE0 counters saturate
  always @(posedge clk) begin
    if (srst) begin
      idleCnt <= 18'h00000;
      se0Cnt <= 9'h000;
      resumeCnt <= 18'h00000;
      busResetActive <= 1'b0;
      dpPrev <= 1'b1;
      vbusPrev <= 1'b0;
    end else begin
      dpPrev <= dpS;
      vbusPrev <= vbusS;
      if (!busIdle) begin
        idleCnt <= 18'h00000;
      end else if (!idleLong) begin
        idleCnt <= idleCnt + 18'h00001;
      end
      if (!se0) begin
        se0Cnt <= 9'h000;
      end else if (se0Cnt != SE0_CYC) begin
        se0Cnt <= se0Cnt + 9'h001;
      end
      if (busRstHit) begin
        busResetActive <= 1'b1;
      end else if (busRstDone) begin
        busResetActive <= 1'b0;
      end
      // K-state length is timed here so the processor needs no timer
      if (state == ST_RESUME) begin
        resumeCnt <= resumeCnt + 18'h00001;
      end else begin
        resumeCnt <= 18'h00000;
      end
    end
  end

  // Resume K drive: D+ low, D- high
  always @(posedge clk) begin
    if (srst) begin
      dpOut <= 1'b0;
      dmOut <= 1'b0;
      dpOe <= 1'b0;
      dmOe <= 1'b0;
    end else begin
      dpOut <= 1'b0;
      dmOut <= next_state == ST_RESUME;
      dpOe <= next_state == ST_RESUME;
      dmOe <= next_state == ST_RESUME;
    end
  end

  // Control bits; chip and bus reset keep them except the pullup gate
  always @(posedge clk) begin
    if (srst) begin
      ctl <= 8'h00;
      pinCtl <= 8'h00;
      generalOutputs <= 4'h0;
    end else begin
      if (wrCtl) begin
        ctl <= wdata & `UWR_CTL_MASK;
      end else if (chipRst || busRstHit) begin
        ctl[`UWR_CTL_PULLUP_GATE] <= 1'b0;
      end
      if (wr && addr == `UWR_ADDR_PIN) begin
        pinCtl <= wdata & `UWR_PIN_MASK;
      end
      if (wr && addr == `UWR_ADDR_GPO) begin
        generalOutputs <= wdata[3:0];
      end
    end
  end

  // Event flags: hardware set beats a same-cycle write-one clear
  always @(posedge clk) begin
    if (srst) begin
      evtFlags <= 8'h00;
      evtEnable <= 8'h00;
      globalIrqEnable <= 1'b0;
    end else if (chipRst) begin
      evtFlags <= 8'h00;
      evtEnable <= 8'h00;
      globalIrqEnable <= 1'b0;
    end else begin
      if (busRstHit) begin
        evtFlags <= (evtFlags & `UWR_EVT_BUSRST_KEEP) | 8'h08;
        evtEnable <= evtEnable & `UWR_EVT_BUSRST_KEEP;
      end else begin
        evtFlags <= ((evtFlags & ~(wrEvt ? wdata : 8'h00))
          | {1'b0,
             vbusPrev && !vbusS,
             !vbusPrev && vbusS,
             busRstDone,
             1'b0,
             suspendHit,
             resumeEnd,
             oscHit})
          & `UWR_EVT_MASK;
        if (wr && addr == `UWR_ADDR_ENA) begin
          evtEnable <= wdata & `UWR_EVT_MASK;
        end
      end
      // Global enable survives a bus reset
      if (wr && addr == `UWR_ADDR_GIE) begin
        globalIrqEnable <= wdata[0];
      end
    end
  end

  // Buffer-free flags come back set after power-on or chip reset
  always @(posedge clk) begin
    if (srst || chipRst) begin
      inBufFlags <= `UWR_INBUF_RST;
    end else if (wrInBuf) begin
      inBufFlags <= inBufFlags & ~(wdata & `UWR_INBUF_MASK);
    end
  end

  // Pin outputs: pullup, multi-function output, interrupt
  wire anyIrq = globalIrqEnable && |(evtFlags & evtEnable);
  wire irqActive = pinCtl[`UWR_PIN_IRQLVL] ? anyIrq : anyIrq && !irqPrev;
  always @(posedge clk) begin
    if (srst) begin
      pullupOn <= 1'b0;
      multiFunctionOutput <= 1'b0;
      irqPin <= 1'b1;
      irqPrev <= 1'b0;
      serialDuplexSelect <= 1'b0;
    end else begin
      // Gate wins over attach so, with the gate set, a dead VBUS never powers the pullup
      pullupOn <= ctl[`UWR_CTL_ATTACH]
        && !(ctl[`UWR_CTL_PULLUP_GATE] && !vbusS);
      case ({pinCtl[`UWR_PIN_MSEL_HI], pinCtl[`UWR_PIN_MSEL_LO]})
        `UWR_MSEL_VBUS: multiFunctionOutput <= vbusS;
        `UWR_MSEL_OSC: multiFunctionOutput <= oscStable;
        `UWR_MSEL_SUSP: multiFunctionOutput <= evtFlags[`UWR_EVT_SUSP];
        default: multiFunctionOutput <= busResetActive;
      endcase
      // Interrupt pin keeps working in power-down
      irqPrev <= anyIrq;
      irqPin <= pinCtl[`UWR_PIN_IRQPOL] ? irqActive : !irqActive;
      serialDuplexSelect <= pinCtl[`UWR_PIN_DUPLEX];
    end
  end

  // Read port: data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (srst || !rd) begin
      rdata <= 8'h00;
    end else begin
      case (addr)
        `UWR_ADDR_CTL: rdata <= ctl;
        `UWR_ADDR_PIN: rdata <= pinCtl;
        `UWR_ADDR_GPO: rdata <= {4'h0, generalOutputs};
        `UWR_ADDR_EVT: rdata <= evtFlags;
        `UWR_ADDR_ENA: rdata <= evtEnable;
        `UWR_ADDR_GIE: rdata <= {7'h00, globalIrqEnable};
        `UWR_ADDR_INBUF: rdata <= inBufFlags;
        `UWR_ADDR_STAT: rdata <= {vbusS, busResetActive, oscStable, 2'h0, state};
        default: rdata <= 8'h00;
      endcase
    end
  end
endmodule

/* File: test/uwr_ctrl_props.sv */
// Port-level checks for the wake, reset and attach controller.
// Assumes binding to every controller instance, with its parameters passed on.
`timescale 1ns/1ns
module uwr_ctrl_props #(
  parameter [17:0] RESUME_CYC = 18'h000C8,
  parameter [17:0] IDLE_CYC = 18'h00064
) (
  input wire clk,
  input wire srst,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire resetPinN,
  input wire dpIn,
  input wire dmIn,
  input wire dpOut,
  input wire dpOe,
  input wire dmOut,
  input wire dmOe,
  input wire pullupOn,
  input wire oscEnable
);
  reg [17:0] kCnt;
  reg [17:0] idleCnt;
  reg attachSh;
  reg hwSh;
  reg pdSh;
  reg rwSh;
  // Control bits other than the pullup gate only software or power-on change, so a write shadow suffices
  always @(posedge clk) begin
    if (srst) begin
      attachSh <= 1'b0;
      hwSh <= 1'b0;
      pdSh <= 1'b0;
      rwSh <= 1'b0;
    end else if (wr && addr == 4'h0) begin
      attachSh <= wdata[4];
      hwSh <= wdata[2];
      pdSh <= wdata[0];
      rwSh <= wdata[1];
    end
  end
  // Run lengths of the resume drive and of idle J on the line
  always @(posedge clk) begin
    if (srst) begin
      kCnt <= 18'h00000;
      idleCnt <= 18'h00000;
    end else begin
      kCnt <= dpOe ? kCnt + 18'h00001 : 18'h00000;
      idleCnt <= (dpIn && !dmIn) ? idleCnt + 18'h00001 : 18'h00000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_kstate; dpOe |-> !dpOut && dmOe && dmOut; endproperty
  property p_kdur; $fell(dpOe) |-> kCnt == RESUME_CYC; endproperty
  property p_kosc; dpOe |-> oscEnable; endproperty
  property p_idle; $rose(dpOe) |-> idleCnt >= IDLE_CYC; endproperty
  property p_pdenter;
    wr && addr == 4'h0 && wdata[0] && !wdata[1] && !wdata[3] && !pdSh && !rwSh && resetPinN
      |-> ##2 !oscEnable;
  endproperty
  property p_pdexit; !oscEnable && wr && addr == 4'h0 && !wdata[0] |-> ##[1:3] oscEnable;
  endproperty
  property p_pinexit; $fell(resetPinN) ##1 !resetPinN [*6] |-> oscEnable; endproperty
  property p_hwake; !oscEnable && hwSh && $fell(dpIn) |-> ##[1:6] oscEnable; endproperty
  property p_attach; pullupOn |-> attachSh || $past(attachSh); endproperty
  a_kstate: assert property (p_kstate) else $error("resume drive not K");
  a_kdur: assert property (p_kdur) else $error("resume length wrong");
  a_kosc: assert property (p_kosc) else $error("resume without clock");
  a_idle: assert property (p_idle) else $error("resume on busy bus");
  a_pdenter: assert property (p_pdenter) else $error("clock not stopped");
  a_pdexit: assert property (p_pdexit) else $error("no exit on clear");
  a_pinexit: assert property (p_pinexit) else $error("no exit on pin");
  a_hwake: assert property (p_hwake) else $error("no host wake");
  a_attach: assert property (p_attach) else $error("pullup not attached");
  c_resume: cover property ($rose(dpOe));
  c_pdown: cover property ($fell(oscEnable));
  c_pullup: cover property ($rose(pullupOn));
endmodule
bind uwr_wake_reset_ctrl uwr_ctrl_props #(.RESUME_CYC(RESUME_CYC), .IDLE_CYC(IDLE_CYC))
  u_props (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
  .wr(wr), .resetPinN(resetPinN), .dpIn(dpIn), .dmIn(dmIn), .dpOut(dpOut), .dpOe(dpOe),
  .dmOut(dmOut), .dmOe(dmOe), .pullupOn(pullupOn), .oscEnable(oscEnable));

/* File: test/uwr_host_model.sv */
// Host side of the bus: line states on its own bit clock, and VBUS.
// Assumes the device drives the lines only while its enables are high.
`timescale 1ns/1ns
module uwr_host_model (
  input wire dpOut,
  input wire dpOe,
  input wire dmOut,
  input wire dmOe,
  output wire dpLine,
  output wire dmLine,
  output reg vbus
);
  reg linkClk = 1'b0;
  reg hostDp = 1'b1;
  reg hostDm = 1'b0;
  initial vbus = 1'b0;
  // Bit clock unrelated in phase to the system clock
  initial begin
    #7;
    forever #200 linkClk = ~linkClk;
  end
  // Device drive wins while it signals resume
  assign dpLine = dpOe ? dpOut : hostDp;
  assign dmLine = dmOe ? dmOut : hostDm;
  // Hold one line state for n bit times, then return to idle J
  task lineState(input p, input m, input integer n);
    begin
      @(posedge linkClk);
      hostDp <= p;
      hostDm <= m;
      repeat (n) @(posedge linkClk);
      hostDp <= 1'b1;
      hostDm <= 1'b0;
    end
  endtask
  task setVbus(input v);
    begin
      @(posedge linkClk);
      vbus <= v;
    end
  endtask
endmodule

/* File: test/uwr_wake_reset_ctrl_bench.sv */
// Self-checking bench for the wake, reset and attach controller.
// Assumes the host model and the bound checker are compiled beside it.
`timescale 1ns/1ns
module uwr_wake_reset_ctrl_bench;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg resetPinN = 1'b1;
  wire [7:0] rdata;
  wire [3:0] gpo;
  wire dpLine, dmLine, dpOut, dpOe, dmOut, dmOe, vbus, pullupOn, oscEnable, mfo, duplex, irq;
  integer errCount = 0;
  integer checkCount = 0;
  integer n;
  // 20 MHz system clock
  always #25 clk = ~clk;
  // Long counts shortened so the run stays brief
  uwr_wake_reset_ctrl #(.RESUME_CYC(18'h000C8), .IDLE_CYC(18'h00064),
    .SUSPEND_CYC(18'h0003C)) u_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .resetPinN(resetPinN), .vbusSenseInput(vbus),
    .dpIn(dpLine), .dpOut(dpOut), .dpOe(dpOe), .dmIn(dmLine), .dmOut(dmOut), .dmOe(dmOe),
    .pullupOn(pullupOn), .oscEnable(oscEnable), .irqPin(irq), .multiFunctionOutput(mfo),
    .generalOutputs(gpo), .serialDuplexSelect(duplex));
  uwr_host_model u_host (.dpOut(dpOut), .dpOe(dpOe), .dmOut(dmOut), .dmOe(dmOe),
    .dpLine(dpLine), .dmLine(dmLine), .vbus(vbus));
  task closeOut;
    begin
      $display("checks %0d mismatches %0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checkCount = checkCount + 1;
      if (got !== exp) begin
        errCount = errCount + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Step past k edges so their updates have landed
  task tick(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  task wreg(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rchk(input [3:0] a, input [7:0] e, input [7:0] m);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata & m, e);
    end
  endtask
  // Bounded wait on the resume drive; the count is left in n
  task waitOe(input v, input integer lim);
    begin
      n = 0;
      while (dpOe !== v && n < lim) begin
        tick(1);
        n = n + 1;
      end
      if (n == lim) begin
        errCount = errCount + 1;
        closeOut;
      end
    end
  endtask
  // Guards against a hang anywhere in the sequence
  initial begin
    repeat (40000) @(posedge clk);
    errCount = errCount + 1;
    closeOut;
  end
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rchk(4'h6, 8'h0D, 8'hFF);
    rchk(4'h0, 8'h00, 8'hFF);
    tick(2100);
    rchk(4'h3, 8'h05, 8'h07);
    chk({7'h00, oscEnable}, 8'h01);
    // Pullup follows attach, gated by VBUS; selector 00 shows VBUS
    wreg(4'h1, 8'h00);
    wreg(4'h0, 8'h30);
    tick(4);
    chk({7'h00, pullupOn}, 8'h00);
    u_host.setVbus(1'b1);
    tick(6);
    chk({6'h00, pullupOn, mfo}, 8'h03);
    rchk(4'h3, 8'h20, 8'h60);
    u_host.setVbus(1'b0);
    tick(6);
    chk({6'h00, pullupOn, mfo}, 8'h00);
    rchk(4'h3, 8'h40, 8'h40);
    u_host.setVbus(1'b1);
    // Soft chip reset keeps port and pin controls, clears enables, sets buffer-free flags
    wreg(4'h2, 8'h0A);
    wreg(4'h1, 8'h37);
    wreg(4'h4, 8'h7F);
    wreg(4'h5, 8'h01);
    wreg(4'h6, 8'h0D);
    rchk(4'h6, 8'h00, 8'hFF);
    wreg(4'h0, 8'h1C);
    tick(3);
    rchk(4'h4, 8'h00, 8'hFF);
    rchk(4'h5, 8'h00, 8'hFF);
    rchk(4'h6, 8'h0D, 8'hFF);
    rchk(4'h2, 8'h0A, 8'hFF);
    rchk(4'h1, 8'h37, 8'hFF);
    rchk(4'h0, 8'h1C, 8'h3F);
    chk({3'h0, duplex, gpo}, 8'h1A);
    wreg(4'h0, 8'h10);
    wreg(4'h1, 8'h07);
    tick(2);
    wreg(4'h4, 8'h7F);
    rchk(4'h4, 8'h7F, 8'hFF);
    // Power-down by software, VBUS still shown; then exit by clearing
    wreg(4'h0, 8'h11);
    tick(3);
    chk({6'h00, oscEnable, mfo}, 8'h01);
    wreg(4'h0, 8'h10);
    tick(3);
    chk({7'h00, oscEnable}, 8'h01);
    // Reset pin ends power-down but keeps the request bit
    wreg(4'h0, 8'h11);
    tick(3);
    resetPinN <= 1'b0;
    tick(8);
    chk({7'h00, oscEnable}, 8'h01);
    resetPinN <= 1'b1;
    rchk(4'h4, 8'h00, 8'hFF);
    rchk(4'h0, 8'h11, 8'h3F);
    wreg(4'h0, 8'h10);
    // Falling D+ with host wake enabled restarts the oscillator
    wreg(4'h0, 8'h15);
    tick(3);
    chk({7'h00, oscEnable}, 8'h00);
    u_host.lineState(1'b0, 1'b1, 2);
    tick(4);
    chk({7'h00, oscEnable}, 8'h01);
    wreg(4'h0, 8'h10);
    // Long SE0: bus reset sets its own flags, keeps its own enables and global enable
    wreg(4'h3, 8'h7F);
    wreg(4'h4, 8'h7F);
    wreg(4'h5, 8'h01);
    u_host.lineState(1'b0, 1'b0, 60);
    tick(4);
    rchk(4'h3, 8'h18, 8'h18);
    rchk(4'h4, 8'h18, 8'hFF);
    rchk(4'h5, 8'h01, 8'hFF);
    chk({7'h00, irq}, 8'h01);
    rchk(4'h2, 8'h0A, 8'hFF);
    // Clearing the kept bus-reset flags drops the level interrupt
    wreg(4'h3, 8'h18);
    tick(2);
    chk({7'h00, irq}, 8'h00);
    // Remote wake: settle and idle wait, then a timed K and the done flag
    wreg(4'h0, 8'h11);
    wreg(4'h0, 8'h13);
    waitOe(1'b1, 4000);
    waitOe(1'b0, 400);
    chk(n[7:0], 8'hC8);
    rchk(4'h3, 8'h02, 8'h02);
    wreg(4'h0, 8'h10);
    rchk(4'h7, 8'h00, 8'h07);
    closeOut;
  end
endmodule
